// file: urmd_top.sv
/*
  Register map decode for one serial channel: selects the register behind
  each of the eight slots and holds the locally stored control bytes.
  Assumes strobes, offset and status come from logic on CLK_IN, and that
  the FIFOs, 650/950 sets and indexed set live outside and take strobes.
*/
`timescale 1ns/1ns
`default_nettype none

module urmd_top (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Host access
  input wire logic RD_IN,
  input wire logic WR_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  output logic RVALID_OUT,
  // Channel status
  input wire urmd_pkg::urmd_stat_t STAT_IN,
  // Strobes to outside registers
  output logic EXT_WR_OUT,
  output logic EXT_RD_OUT,
  output urmd_pkg::urmd_sel_t EXT_SEL_OUT,
  output logic [2:0] EXT_ADDR_OUT,
  output logic [7:0] EXT_WDATA_OUT,
  // Stored control
  output logic [7:0] LINE_FORMAT_CONTROL_OUT,
  output logic [7:0] INTERRUPT_ENABLE_REG_OUT,
  output logic [7:0] MODEM_CONTROL_REG_OUT,
  output logic [15:0] DIVISOR_OUT,
  output logic [7:0] SCRATCH_AND_INDEX_OUT,
  output logic UNLOCK_OUT,
  output logic TX_NINTH_OUT
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Priority: unlock, divisor access, read overlays, then the plain map
  function automatic urmd_pkg::urmd_sel_t decode(
    input logic [2:0] a,
    input logic rd,
    input logic dlab,
    input logic unl,
    input logic st950,
    input logic idx_rd
  );
    urmd_pkg::urmd_sel_t s;
    s = urmd_pkg::SEL_NONE;
    if (unl && a != urmd_pkg::OFS_DATA && a != urmd_pkg::OFS_INT_EN &&
        a != urmd_pkg::OFS_LINE_FMT) begin
      s = urmd_pkg::SEL_ENH_SET;
    end else if (dlab && a == urmd_pkg::OFS_DATA) begin
      s = urmd_pkg::SEL_DIV_LOW;
    end else if (dlab && a == urmd_pkg::OFS_INT_EN) begin
      s = urmd_pkg::SEL_DIV_HIGH;
    end else if (rd && st950 && (a == urmd_pkg::OFS_INT_EN ||
                 a == urmd_pkg::OFS_LINE_FMT || a == urmd_pkg::OFS_MODEM_CTL)) begin
      s = urmd_pkg::SEL_STATUS_950;
    end else if (rd && idx_rd && a == urmd_pkg::OFS_LINE_STAT) begin
      s = urmd_pkg::SEL_INDEXED;
    end else begin
      case (a)
        urmd_pkg::OFS_DATA: s = rd ? urmd_pkg::SEL_RX_HOLD : urmd_pkg::SEL_TX_HOLD;
        urmd_pkg::OFS_INT_EN: s = urmd_pkg::SEL_INT_EN;
        urmd_pkg::OFS_INT_STAT: s = rd ? urmd_pkg::SEL_INT_STAT : urmd_pkg::SEL_FIFO_CTL;
        urmd_pkg::OFS_LINE_FMT: s = urmd_pkg::SEL_LINE_FMT;
        urmd_pkg::OFS_MODEM_CTL: s = urmd_pkg::SEL_MODEM_CTL;
        // Writes to the status slot reach the indexed set through the index
        urmd_pkg::OFS_LINE_STAT: s = rd ? urmd_pkg::SEL_LINE_STAT : urmd_pkg::SEL_INDEXED;
        urmd_pkg::OFS_MODEM_STAT: s = rd ? urmd_pkg::SEL_MODEM_STAT : urmd_pkg::SEL_NONE;
        urmd_pkg::OFS_SCRATCH: s = urmd_pkg::SEL_SCRATCH;
        default: s = urmd_pkg::SEL_NONE;
      endcase
    end
    return s;
  endfunction

  logic [7:0] line_fmt_q;
  logic unlock_q;
  logic [7:0] int_en_q;
  logic [7:0] modem_ctl_q;
  logic [7:0] scratch_q;
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic ext_wr_q;
  logic ext_rd_q;
  urmd_pkg::urmd_sel_t ext_sel_q;
  logic [2:0] ext_addr_q;
  logic [7:0] ext_wdata_q;
  urmd_pkg::urmd_sel_t rd_sel;
  urmd_pkg::urmd_sel_t wr_sel;
  logic [7:0] rd_mux;
  logic dlab;

  assign dlab = line_fmt_q[urmd_pkg::DLAB_BIT];
  assign rd_sel = decode(ADDR_IN, 1'b1, dlab, unlock_q, STAT_IN.status_950_en,
                         STAT_IN.indexed_rd_en);
  assign wr_sel = decode(ADDR_IN, 1'b0, dlab, unlock_q, STAT_IN.status_950_en,
                         STAT_IN.indexed_rd_en);

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    case (rd_sel)
      urmd_pkg::SEL_RX_HOLD: rd_mux = STAT_IN.rx_data;
      urmd_pkg::SEL_DIV_LOW: rd_mux = div_low_q;
      urmd_pkg::SEL_DIV_HIGH: rd_mux = div_high_q;
      urmd_pkg::SEL_INT_EN: rd_mux = int_en_q;
      urmd_pkg::SEL_INT_STAT: begin
        // Enhanced priority bits read zero outside enhanced mode
        rd_mux = {{2{STAT_IN.fifo_enabled}},
                  STAT_IN.enhanced ? STAT_IN.int_prio_enh : 2'h0,
                  STAT_IN.int_prio, STAT_IN.int_pending};
      end
      urmd_pkg::SEL_LINE_FMT: rd_mux = line_fmt_q;
      urmd_pkg::SEL_MODEM_CTL: rd_mux = modem_ctl_q;
      urmd_pkg::SEL_LINE_STAT: begin
        rd_mux = STAT_IN.line_stat;
        if (STAT_IN.nine_bit) begin
          rd_mux[urmd_pkg::NINTH_RX_BIT] = STAT_IN.rx_ninth;
        end
      end
      urmd_pkg::SEL_MODEM_STAT: rd_mux = STAT_IN.modem_stat;
      urmd_pkg::SEL_SCRATCH: rd_mux = scratch_q;
      urmd_pkg::SEL_INDEXED: rd_mux = STAT_IN.indexed_rdata;
      urmd_pkg::SEL_STATUS_950: begin
        case (ADDR_IN)
          urmd_pkg::OFS_INT_EN: rd_mux = STAT_IN.add_stat;
          urmd_pkg::OFS_LINE_FMT: rd_mux = STAT_IN.rx_level;
          default: rd_mux = STAT_IN.tx_level;
        endcase
      end
      urmd_pkg::SEL_ENH_SET: begin
        case (ADDR_IN)
          urmd_pkg::OFS_INT_STAT: rd_mux = STAT_IN.enh_features;
          urmd_pkg::OFS_MODEM_CTL: rd_mux = STAT_IN.xon1;
          urmd_pkg::OFS_LINE_STAT: rd_mux = STAT_IN.xon2;
          urmd_pkg::OFS_MODEM_STAT: rd_mux = STAT_IN.xoff1;
          default: rd_mux = STAT_IN.xoff2;
        endcase
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Host answer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= RD_IN;
      if (RD_IN) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line format and unlock
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      line_fmt_q <= urmd_pkg::RST_LINE_FMT;
      unlock_q <= 1'b0;
    end else if (WR_IN && wr_sel == urmd_pkg::SEL_LINE_FMT) begin
      if (WDATA_IN == urmd_pkg::UNLOCK_VAL) begin
        // Character format must not glitch while the 650 set is open
        line_fmt_q[urmd_pkg::DLAB_BIT] <= 1'b1;
        unlock_q <= 1'b1;
      end else begin
        line_fmt_q <= WDATA_IN;
        unlock_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Locally stored bytes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      int_en_q <= urmd_pkg::RST_INT_EN;
      modem_ctl_q <= urmd_pkg::RST_MODEM_CTL;
      scratch_q <= urmd_pkg::RST_SCRATCH;
      div_low_q <= urmd_pkg::RST_DIVISOR;
      div_high_q <= urmd_pkg::RST_DIVISOR;
    end else if (WR_IN) begin
      case (wr_sel)
        urmd_pkg::SEL_INT_EN: int_en_q <= WDATA_IN;
        urmd_pkg::SEL_MODEM_CTL: modem_ctl_q <= WDATA_IN;
        urmd_pkg::SEL_SCRATCH: scratch_q <= WDATA_IN;
        urmd_pkg::SEL_DIV_LOW: div_low_q <= WDATA_IN;
        urmd_pkg::SEL_DIV_HIGH: div_high_q <= WDATA_IN;
        default: int_en_q <= int_en_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Strobes to outside registers
  // ----------------------------------------------------------------
  // Reads strobe too, so the FIFO pops and status clears happen on read
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ext_wr_q <= 1'b0;
      ext_rd_q <= 1'b0;
      ext_sel_q <= urmd_pkg::SEL_NONE;
      ext_addr_q <= 3'h0;
      ext_wdata_q <= 8'h00;
    end else begin
      ext_wr_q <= WR_IN && (wr_sel == urmd_pkg::SEL_TX_HOLD ||
                  wr_sel == urmd_pkg::SEL_FIFO_CTL || wr_sel == urmd_pkg::SEL_ENH_SET ||
                  wr_sel == urmd_pkg::SEL_INDEXED);
      ext_rd_q <= RD_IN && !WR_IN;
      if (WR_IN) begin
        ext_sel_q <= wr_sel;
        ext_addr_q <= ADDR_IN;
        ext_wdata_q <= WDATA_IN;
      end else if (RD_IN) begin
        ext_sel_q <= rd_sel;
        ext_addr_q <= ADDR_IN;
      end
    end
  end

  assign RDATA_OUT = rdata_q;
  assign RVALID_OUT = rvalid_q;
  assign EXT_WR_OUT = ext_wr_q;
  assign EXT_RD_OUT = ext_rd_q;
  assign EXT_SEL_OUT = ext_sel_q;
  assign EXT_ADDR_OUT = ext_addr_q;
  assign EXT_WDATA_OUT = ext_wdata_q;
  assign LINE_FORMAT_CONTROL_OUT = line_fmt_q;
  assign INTERRUPT_ENABLE_REG_OUT = int_en_q;
  assign MODEM_CONTROL_REG_OUT = modem_ctl_q;
  assign DIVISOR_OUT = {div_high_q, div_low_q};
  assign SCRATCH_AND_INDEX_OUT = scratch_q;
  assign UNLOCK_OUT = unlock_q;
  assign TX_NINTH_OUT = scratch_q[urmd_pkg::NINTH_TX_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence unlock_wr_s;
    WR_IN && !RD_IN && ADDR_IN == urmd_pkg::OFS_LINE_FMT && WDATA_IN == urmd_pkg::UNLOCK_VAL;
  endsequence
  sequence plain_rd_s(logic [2:0] a);
    RD_IN && !WR_IN && !unlock_q && !STAT_IN.status_950_en && ADDR_IN == a;
  endsequence

  rd_answer_a: assert property (RD_IN |=> RVALID_OUT)
    else $error("read answer missing");
  div_low_rd_a: assert property (plain_rd_s(urmd_pkg::OFS_DATA) and dlab
    |=> RDATA_OUT == $past(div_low_q))
    else $error("divisor low not read");
  unlock_flag_a: assert property (unlock_wr_s |=> UNLOCK_OUT)
    else $error("unlock not held");
  fmt_kept_a: assert property (unlock_wr_s |=> LINE_FORMAT_CONTROL_OUT[7] &&
    LINE_FORMAT_CONTROL_OUT[6:0] == $past(line_fmt_q[6:0]))
    else $error("format bits changed on unlock");
  tx_load_a: assert property (WR_IN && ADDR_IN == urmd_pkg::OFS_DATA && !dlab
    |=> EXT_WR_OUT && EXT_SEL_OUT == urmd_pkg::SEL_TX_HOLD &&
    EXT_WDATA_OUT == $past(WDATA_IN))
    else $error("transmit load missing");
  stat950_rd_a: assert property (RD_IN && !WR_IN && !unlock_q && STAT_IN.status_950_en &&
    ADDR_IN == urmd_pkg::OFS_MODEM_CTL |=> RDATA_OUT == $past(STAT_IN.tx_level))
    else $error("status 950 read wrong");
  indexed_rd_a: assert property (plain_rd_s(urmd_pkg::OFS_LINE_STAT) and STAT_IN.indexed_rd_en
    |=> RDATA_OUT == $past(STAT_IN.indexed_rdata))
    else $error("indexed read wrong");
  int_stat_rd_a: assert property (plain_rd_s(urmd_pkg::OFS_INT_STAT)
    |=> RDATA_OUT[7:6] == {2{$past(STAT_IN.fifo_enabled)}} &&
    RDATA_OUT[3:0] == {$past(STAT_IN.int_prio), $past(STAT_IN.int_pending)})
    else $error("interrupt status read wrong");
  ninth_tx_a: assert property (WR_IN && !unlock_q && ADDR_IN == urmd_pkg::OFS_SCRATCH
    |=> TX_NINTH_OUT == $past(WDATA_IN[0]) && SCRATCH_AND_INDEX_OUT == $past(WDATA_IN))
    else $error("scratch byte not stored");

endmodule
`default_nettype wire

// file: urmd_pkg.sv
/*
  Shared constants and types for the serial channel register map decode.
  Assumes one host access at a time, on the shared channel clock.
*/
`default_nettype none
package urmd_pkg;

  // ----------------------------------------------------------------
  // Slot offsets within the 8-byte channel window
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_INT_EN = 3'h1;
  localparam logic [2:0] OFS_INT_STAT = 3'h2;
  localparam logic [2:0] OFS_LINE_FMT = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  // ----------------------------------------------------------------
  // Field positions, key values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_VAL = 8'hBF;
  localparam int DLAB_BIT = 7;
  localparam int NINTH_TX_BIT = 0;
  localparam int NINTH_RX_BIT = 2;
  localparam logic [7:0] RST_LINE_FMT = 8'h00;
  localparam logic [7:0] RST_INT_EN = 8'h00;
  localparam logic [7:0] RST_MODEM_CTL = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_DIVISOR = 8'h00;

  // ----------------------------------------------------------------
  // Register selected by one access
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_RX_HOLD = 4'h1,
    SEL_TX_HOLD = 4'h2,
    SEL_DIV_LOW = 4'h3,
    SEL_DIV_HIGH = 4'h4,
    SEL_INT_EN = 4'h5,
    SEL_INT_STAT = 4'h6,
    SEL_FIFO_CTL = 4'h7,
    SEL_LINE_FMT = 4'h8,
    SEL_MODEM_CTL = 4'h9,
    SEL_LINE_STAT = 4'hA,
    SEL_MODEM_STAT = 4'hB,
    SEL_SCRATCH = 4'hC,
    SEL_ENH_SET = 4'hD,
    SEL_STATUS_950 = 4'hE,
    SEL_INDEXED = 4'hF
  } urmd_sel_t;

  // Live state from the rest of the channel
  typedef struct packed {
    logic [7:0] rx_data;
    logic int_pending;
    logic [2:0] int_prio;
    logic [1:0] int_prio_enh;
    logic fifo_enabled;
    logic enhanced;
    logic nine_bit;
    logic [7:0] line_stat;
    logic rx_ninth;
    logic [7:0] modem_stat;
    logic [7:0] add_stat;
    logic [7:0] rx_level;
    logic [7:0] tx_level;
    logic [7:0] indexed_rdata;
    logic [7:0] enh_features;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
    logic status_950_en;
    logic indexed_rd_en;
  } urmd_stat_t;

endpackage
`default_nettype wire

// file: urmd_host_model.sv
/*
  Host side of the channel window: issues one-cycle read or write strobes.
  Assumes callers enter its tasks just after a rising edge of clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module urmd_host_model (
  // Clock
  input wire logic clk_in,
  // Host access
  output logic rd_out,
  output logic wr_out,
  output logic [2:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 3'h0;
    wdata_out = 8'h00;
  end

  // Strobe and qualifiers held through exactly one taking edge
  task automatic access(input logic rd, input logic [2:0] addr, input logic [7:0] data);
    rd_out = rd;
    wr_out = ~rd;
    addr_out = addr;
    wdata_out = data;
    @(posedge clk_in);
    #1;
  endtask

  // Released address and data lines show inverted values, so stale data never looks valid
  task automatic release_bus();
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
    @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
/*
  Self-checking bench for the channel register map decode.
  Assumes the host model above and randomised channel status on STAT_IN.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct packed {
    urmd_pkg::urmd_sel_t sel;
    logic [7:0] data;
  } urmd_exp_t;
  logic clk, resetn, host_rd, host_wr, rvalid, ext_wr, ext_rd, unlock, tx_ninth;
  logic [2:0] addr, ext_addr;
  logic [7:0] wdata, rdata, ext_wdata, lfmt, ien, mctl, scr, v, a, b, ie, s7;
  logic [15:0] div;
  urmd_pkg::urmd_sel_t ext_sel;
  urmd_pkg::urmd_stat_t stat;
  logic [31:0] lfsr_q = 32'h8C34EBEC;
  int errors = 0;
  int tests_run = 0;
  urmd_exp_t exp_q[$];

  urmd_host_model host (.clk_in(clk), .rd_out(host_rd), .wr_out(host_wr), .addr_out(addr),
    .wdata_out(wdata));
  urmd_top uut (.CLK_IN(clk), .RESETN_IN(resetn), .RD_IN(host_rd), .WR_IN(host_wr),
    .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .STAT_IN(stat),
    .EXT_WR_OUT(ext_wr), .EXT_RD_OUT(ext_rd), .EXT_SEL_OUT(ext_sel), .EXT_ADDR_OUT(ext_addr),
    .EXT_WDATA_OUT(ext_wdata), .LINE_FORMAT_CONTROL_OUT(lfmt), .INTERRUPT_ENABLE_REG_OUT(ien),
    .MODEM_CONTROL_REG_OUT(mctl), .DIVISOR_OUT(div), .SCRATCH_AND_INDEX_OUT(scr),
    .UNLOCK_OUT(unlock), .TX_NINTH_OUT(tx_ninth));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic void rnd(output logic [7:0] r);
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    r = lfsr_q[7:0];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string msg);
    tests_run++;
    if (got !== want) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, want);
    end
  endtask

  task automatic new_stat(input logic e950, input logic eidx, input logic nine, input logic enh);
    for (int i = 0; i < 14; i++) begin
      rnd(v);
      stat = {stat[99:0], v};
    end
    stat.status_950_en = e950;
    stat.indexed_rd_en = eidx;
    stat.nine_bit = nine;
    stat.enhanced = enh;
  endtask

  task automatic wr(input logic [2:0] ad, input logic [7:0] d, input logic ext,
    input urmd_pkg::urmd_sel_t s);
    host.access(1'b0, ad, d);
    chk({15'h0, ext_wr}, {15'h0, ext}, "outside write strobe");
    if (ext) begin
      chk({12'h0, ext_sel}, {12'h0, s}, "write select");
      chk({8'h0, ext_wdata}, {8'h0, d}, "write data");
      chk({13'h0, ext_addr}, {13'h0, ad}, "write offset");
    end
  endtask

  task automatic rd(input logic [2:0] ad, input urmd_pkg::urmd_sel_t s, input logic [7:0] d);
    exp_q.push_back({s, d});
    host.access(1'b1, ad, 8'h00);
  endtask

  task automatic close_out();
    if (exp_q.size() != 0)
      errors++;
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reads are answered on the taking edge and checked 2 ns after it
  always @(posedge clk) begin : watch
    urmd_exp_t e;
    #2;
    if (rvalid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : {urmd_pkg::SEL_NONE, ~rdata};
      chk({8'h0, rdata}, {8'h0, e.data}, "read data");
      chk({12'h0, ext_sel}, {12'h0, e.sel}, "read select");
      chk({15'h0, ext_rd}, 16'h1, "outside read strobe");
    end
  end

  initial begin
    #100000;
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    stat = '0;
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk({lfmt, ien}, 16'h0000, "reset line format and enable");
    chk({8'h0, unlock, tx_ninth, rvalid, ext_wr, ext_sel}, 16'h0, "reset flags");
    new_stat(1'b0, 1'b0, 1'b0, 1'b0);
    // Plain map, back to back
    rnd(v);
    ie = v;
    wr(urmd_pkg::OFS_INT_EN, v, 1'b0, urmd_pkg::SEL_NONE);
    rd(urmd_pkg::OFS_INT_EN, urmd_pkg::SEL_INT_EN, v);
    rnd(v);
    wr(urmd_pkg::OFS_MODEM_CTL, v, 1'b0, urmd_pkg::SEL_NONE);
    rd(urmd_pkg::OFS_MODEM_CTL, urmd_pkg::SEL_MODEM_CTL, v);
    chk({8'h0, mctl}, {8'h0, v}, "modem control level");
    rnd(v);
    wr(urmd_pkg::OFS_SCRATCH, v, 1'b0, urmd_pkg::SEL_NONE);
    s7 = v;
    chk({scr, 7'h0, tx_ninth}, {v, 7'h0, v[0]}, "scratch and ninth bit");
    rd(urmd_pkg::OFS_SCRATCH, urmd_pkg::SEL_SCRATCH, v);
    wr(urmd_pkg::OFS_LINE_STAT, v, 1'b1, urmd_pkg::SEL_INDEXED);
    wr(urmd_pkg::OFS_DATA, v, 1'b1, urmd_pkg::SEL_TX_HOLD);
    rd(urmd_pkg::OFS_DATA, urmd_pkg::SEL_RX_HOLD, stat.rx_data);
    wr(urmd_pkg::OFS_INT_STAT, v, 1'b1, urmd_pkg::SEL_FIFO_CTL);
    rd(urmd_pkg::OFS_INT_STAT, urmd_pkg::SEL_INT_STAT, {{2{stat.fifo_enabled}}, 2'b00,
      stat.int_prio, stat.int_pending});
    wr(urmd_pkg::OFS_MODEM_STAT, v, 1'b0, urmd_pkg::SEL_NONE);
    rd(urmd_pkg::OFS_MODEM_STAT, urmd_pkg::SEL_MODEM_STAT, stat.modem_stat);
    rd(urmd_pkg::OFS_LINE_STAT, urmd_pkg::SEL_LINE_STAT, stat.line_stat);
    host.release_bus();
    new_stat(1'b0, 1'b0, 1'b1, 1'b1);
    rd(urmd_pkg::OFS_INT_STAT, urmd_pkg::SEL_INT_STAT, {{2{stat.fifo_enabled}},
      stat.int_prio_enh, stat.int_prio, stat.int_pending});
    rd(urmd_pkg::OFS_LINE_STAT, urmd_pkg::SEL_LINE_STAT, {stat.line_stat[7:3], stat.rx_ninth,
      stat.line_stat[1:0]});
    // Divisor bytes overlay slots 0 and 1
    wr(urmd_pkg::OFS_LINE_FMT, 8'h83, 1'b0, urmd_pkg::SEL_NONE);
    rnd(a);
    rnd(b);
    wr(urmd_pkg::OFS_DATA, a, 1'b0, urmd_pkg::SEL_NONE);
    wr(urmd_pkg::OFS_INT_EN, b, 1'b0, urmd_pkg::SEL_NONE);
    chk(div, {b, a}, "divisor");
    chk({8'h0, ien}, {8'h0, ie}, "enable kept");
    rd(urmd_pkg::OFS_DATA, urmd_pkg::SEL_DIV_LOW, a);
    rd(urmd_pkg::OFS_INT_EN, urmd_pkg::SEL_DIV_HIGH, b);
    rd(urmd_pkg::OFS_LINE_FMT, urmd_pkg::SEL_LINE_FMT, 8'h83);
    // Unlock keeps the character format
    rnd(a);
    a[7] = 1'b0;
    wr(urmd_pkg::OFS_LINE_FMT, a, 1'b0, urmd_pkg::SEL_NONE);
    wr(urmd_pkg::OFS_LINE_FMT, urmd_pkg::UNLOCK_VAL, 1'b0, urmd_pkg::SEL_NONE);
    chk({7'h0, unlock, lfmt}, {7'h0, 1'b1, 1'b1, a[6:0]}, "unlock format");
    rd(urmd_pkg::OFS_MODEM_CTL, urmd_pkg::SEL_ENH_SET, stat.xon1);
    rd(urmd_pkg::OFS_SCRATCH, urmd_pkg::SEL_ENH_SET, stat.xoff2);
    rd(urmd_pkg::OFS_INT_STAT, urmd_pkg::SEL_ENH_SET, stat.enh_features);
    wr(urmd_pkg::OFS_INT_STAT, b, 1'b1, urmd_pkg::SEL_ENH_SET);
    wr(urmd_pkg::OFS_LINE_FMT, a, 1'b0, urmd_pkg::SEL_NONE);
    chk({7'h0, unlock, lfmt}, {8'h0, a}, "unlock left");
    rd(urmd_pkg::OFS_SCRATCH, urmd_pkg::SEL_SCRATCH, s7);
    host.release_bus();
    // Read overlays from the additional control bits
    new_stat(1'b1, 1'b0, 1'b0, 1'b0);
    rd(urmd_pkg::OFS_INT_EN, urmd_pkg::SEL_STATUS_950, stat.add_stat);
    rd(urmd_pkg::OFS_LINE_FMT, urmd_pkg::SEL_STATUS_950, stat.rx_level);
    rd(urmd_pkg::OFS_MODEM_CTL, urmd_pkg::SEL_STATUS_950, stat.tx_level);
    host.release_bus();
    new_stat(1'b0, 1'b1, 1'b0, 1'b0);
    rd(urmd_pkg::OFS_LINE_STAT, urmd_pkg::SEL_INDEXED, stat.indexed_rdata);
    rd(urmd_pkg::OFS_INT_EN, urmd_pkg::SEL_INT_EN, ie);
    host.release_bus();
    // Second reset in mid-run
    resetn = 1'b0;
    #3;
    chk({lfmt, scr}, 16'h0000, "mid-run reset");
    @(posedge clk);
    #1;
    resetn = 1'b1;
    chk({7'h0, unlock, ien}, {8'h0, urmd_pkg::RST_INT_EN}, "reset enable and unlock");
    chk(div, {2{urmd_pkg::RST_DIVISOR}}, "reset divisor");
    // First access right on the first edge after release
    rd(urmd_pkg::OFS_SCRATCH, urmd_pkg::SEL_SCRATCH, urmd_pkg::RST_SCRATCH);
    host.release_bus();
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
